// ---- dv/tmc_core_monitor.sv ----
// Checker for the timer core: register port answers, pending flags
// and output pin pairs. Sees only the ports of tmc_core.
`timescale 1ns/100ps

module tmc_core_monitor (
	// Clock and reset
	input wire logic       clk,
	input wire logic       rst_n,
	// Register port
	input wire logic [5:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr,
	input wire logic       rd,
	input wire logic [7:0] rdata,
	// Ticks and pins
	input wire logic       hi_tick,
	input wire logic       sub_tick,
	input wire logic [3:0] ext_clock_pin,
	input wire logic [3:0] capture_pin,
	input wire logic [3:0] timer_output_pin,
	input wire logic [1:0] inverted_output_pin,
	// Interrupt requests
	input wire logic [3:0] irq_a,
	input wire logic [3:0] irq_p
);
	// Flags in status register order, A flag in the even bits
	wire logic [7:0] flags_w = {irq_p[3], irq_a[3], irq_p[2], irq_a[2],
		irq_p[1], irq_a[1], irq_p[0], irq_a[0]};
	wire logic       st_wr_w = wr && addr == tmc_pkg::ADDR_STAT;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// Pin pairs, read data and flags
	inv_pin_pair_a: assert property (
		$past(rst_n) |-> inverted_output_pin == ~timer_output_pin[1:0])
		else $error("Inverted pin is not the complement");
	rdata_hold_a: assert property (
		!$past(rd) |-> $stable(rdata))
		else $error("Read data moved without a read");
	unmapped_zero_a: assert property (
		rd && addr[5] && addr != tmc_pkg::ADDR_STAT |=> rdata == 8'h00)
		else $error("Unmapped read not zero");
	status_read_a: assert property (
		rd && addr == tmc_pkg::ADDR_STAT |=> rdata == $past(flags_w))
		else $error("Status read does not match flags");
	flag_a_keep_a: assert property (
		!st_wr_w |=> (irq_a & $past(irq_a)) == $past(irq_a))
		else $error("A flag dropped without a clear");
	flag_p_keep_a: assert property (
		!st_wr_w |=> (irq_p & $past(irq_p)) == $past(irq_p))
		else $error("P flag dropped without a clear");
	flag_clear_a: assert property (
		st_wr_w |=> (flags_w & $past(wdata)) == 8'h00)
		else $error("Flag not cleared by status write");
	ctrl0_gap_a: assert property (
		rd && !addr[5] && addr[2:0] == 3'h0 |=> rdata[2:1] == 2'b00)
		else $error("Unused control bits not zero");
	pt_hi_narrow_a: assert property (
		rd && !addr[5] && addr[4:3] != 2'b00 && addr[0] && addr[2:1] != 2'b00
		|=> rdata[7:2] == 6'h00)
		else $error("Periodic high byte too wide");
	std_p_top_a: assert property (
		rd && addr == 6'h07 |=> rdata == 8'h00)
		else $error("Standard comparator P high byte not zero");
endmodule

bind tmc_core tmc_core_monitor tmc_core_monitor_i (
	.clk                 (clk),
	.rst_n               (rst_n),
	.addr                (addr),
	.wdata               (wdata),
	.wr                  (wr),
	.rd                  (rd),
	.rdata               (rdata),
	.hi_tick             (hi_tick),
	.sub_tick            (sub_tick),
	.ext_clock_pin       (ext_clock_pin),
	.capture_pin         (capture_pin),
	.timer_output_pin    (timer_output_pin),
	.inverted_output_pin (inverted_output_pin),
	.irq_a               (irq_a),
	.irq_p               (irq_p)
);

// ---- dv/tmc_core_test.sv ----
// Self-checking bench for the timer core: byte buffering, compare,
// external clock, capture and PWM. Needs tmc_pkg and the checker.
`timescale 1ns/100ps

module tmc_core_test;
	// Design inputs
	logic       clk = 1'b0;
	logic       rst_n = 1'b0;
	logic [5:0] addr = 6'h00;
	logic [7:0] wdata = 8'h00;
	logic       wr = 1'b0;
	logic       rd = 1'b0;
	logic       hi_tick = 1'b0;
	logic       sub_tick = 1'b0;
	logic [3:0] ext_clock_pin = 4'h0;
	logic [3:0] capture_pin = 4'h0;
	// Design outputs
	logic [7:0] rdata;
	logic [3:0] timer_output_pin;
	logic [1:0] inverted_output_pin;
	logic [3:0] irq_a;
	logic [3:0] irq_p;
	// Bench state
	int         err_count = 0;
	int         n_compared = 0;
	int         m, n, k, t, fn, src, sel;
	logic [7:0] rv, lo, hi, mask;

	tmc_core tmc_core_i (
		.clk                 (clk),
		.rst_n               (rst_n),
		.addr                (addr),
		.wdata               (wdata),
		.wr                  (wr),
		.rd                  (rd),
		.rdata               (rdata),
		.hi_tick             (hi_tick),
		.sub_tick            (sub_tick),
		.ext_clock_pin       (ext_clock_pin),
		.capture_pin         (capture_pin),
		.timer_output_pin    (timer_output_pin),
		.inverted_output_pin (inverted_output_pin),
		.irq_a               (irq_a),
		.irq_p               (irq_p)
	);

	// 25 MHz clock; sparse random ticks keep slow sources nearly still
	always #20 clk = ~clk;
	always @(posedge clk) hi_tick <= ($urandom % 4) == 0;
	always @(posedge clk) sub_tick <= ($urandom % 4) == 0;

	// Compare a seen value with the model
	task automatic check(input logic [15:0] s, input logic [15:0] e);
		n_compared++;
		if (s !== e)
		begin
			err_count++;
			$display("BAD t=%0t seen %h expected %h", $time, s, e);
		end
	endtask

	// Register write, one strobe cycle
	task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
	endtask

	// Register read, data taken in the cycle after the strobe
	task automatic rd_reg(input logic [5:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		#1;
		d = rdata;
	endtask

	// Byte address of register r in module mi
	function automatic logic [5:0] ra(input int mi, input int r);
		return {1'b0, 2'(mi), 3'(r)};
	endfunction

	// Cycles until pin mi shows level lv, bounded
	task automatic wait_pin(input int mi, input logic lv, output int c);
		c = 0;
		#1;
		while (timer_output_pin[mi] !== lv && c < 3000)
		begin
			@(posedge clk);
			#1;
			c++;
		end
	endtask

	// Counts, verdict and end of run
	task automatic report_and_stop;
		$display("Compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Hang guard, far beyond the thousand or so cycles expected
	initial
	begin
		#(40 * 40000);
		err_count++;
		report_and_stop();
	end

	// Main sequence
	initial
	begin
		void'($urandom(32'hFC5D62F8));
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		rd_reg(6'h21, rv);
		check(rv, 8'h00);
		// Low bytes go through the shared buffer; model starts at zero
		for (m = 0; m < 4; m++)
			for (k = 4; k < 8; k += 2)
			begin
				if (m == 0 && k == 6)
					continue;
				mask = (m == 0) ? 8'hFF : 8'h03;
				lo = 8'($urandom);
				hi = 8'($urandom);
				wr_reg(ra(m, k), lo);
				rd_reg(ra(m, k), rv);
				check(rv, lo);
				rd_reg(ra(m, k + 1), rv);
				rd_reg(ra(m, k), rv);
				check(rv, 8'h00);
				wr_reg(ra(m, k), lo);
				wr_reg(ra(m, k + 1), hi);
				rd_reg(ra(m, k + 1), rv);
				check(rv, hi & mask);
				rd_reg(ra(m, k), rv);
				check(rv, lo);
			end
		// Toggle on A match with clear on A: pin toggles every n clocks
		m = $urandom % 4;
		n = 20 + $urandom % 20;
		wr_reg(ra(m, 4), 8'(n));
		wr_reg(ra(m, 5), 8'h00);
		wr_reg(ra(m, 1), 8'h31);
		wr_reg(ra(m, 0), 8'h18);
		wait_pin(m, 1'b1, t);
		wait_pin(m, 1'b0, t);
		check(16'(t), 16'(n));
		wait_pin(m, 1'b1, t);
		check(16'(t), 16'(n));
		check(irq_a[m], 1'b1);
		repeat (n - 6) @(posedge clk);
		wr_reg(ra(m, 0), 8'h10);
		rd_reg(ra(m, 3), rv);
		rd_reg(ra(m, 2), lo);
		repeat (5) @(posedge clk);
		rd_reg(ra(m, 3), rv);
		rd_reg(ra(m, 2), rv);
		check(rv, lo);
		wr_reg(ra(m, 0), 8'h18);
		rd_reg(ra(m, 3), rv);
		rd_reg(ra(m, 2), rv);
		check(rv < 8 && lo >= 8, 1'b1);
		check(timer_output_pin[m], 1'b0);
		wr_reg(ra(m, 0), 8'h10);
		wr_reg(tmc_pkg::ADDR_STAT, 8'(1 << (2 * m)));
		#1;
		check(irq_a[m], 1'b0);
		// External pin clock, rising then falling edge; pin left high
		m = $urandom % 4;
		wr_reg(ra(m, 1), 8'hC0);
		// Park P far above the pulse count so it cannot clear it
		wr_reg(ra(m, 7), 8'h03);
		for (sel = 6; sel < 8; sel++)
		begin
			k = 3 + $urandom % 5;
			wr_reg(ra(m, 0), 8'((sel << 4) | 8));
			repeat (4) @(posedge clk);
			repeat (k)
			begin
				ext_clock_pin[m] <= 1'b1;
				repeat (4) @(posedge clk);
				ext_clock_pin[m] <= 1'b0;
				repeat (4) @(posedge clk);
			end
			ext_clock_pin[m] <= 1'b1;
			repeat (5) @(posedge clk);
			rd_reg(ra(m, 3), rv);
			rd_reg(ra(m, 2), rv);
			check(rv, 16'((sel == 6) ? k + 1 : k));
			wr_reg(ra(m, 0), 8'h00);
			ext_clock_pin[m] <= 1'b0;
			repeat (5) @(posedge clk);
		end
		// Capture edges on periodic zero; slow clock so A cannot match
		m = 1;
		for (src = 0; src < 2; src++)
			for (fn = 0; fn < 4; fn++)
			begin
				wr_reg(ra(m, 1), 8'(8'h40 | (fn << 4)));
				wr_reg(ra(m, 0), 8'(8'h38 | src));
				wr_reg(tmc_pkg::ADDR_STAT, 8'hFF);
				for (k = 1; k >= 0; k--)
				begin
					if (src == 1)
						ext_clock_pin[m] <= k[0];
					else
						capture_pin[m] <= k[0];
					repeat (6) @(posedge clk);
					#1;
					check(irq_a[m], fn == 2 || fn == 1 - k);
					wr_reg(tmc_pkg::ADDR_STAT, 8'hFF);
				end
				wr_reg(ra(m, 0), 8'h00);
			end
		// PWM on periodic zero: period from P, active time from A
		n = 5 + $urandom % 10;
		k = n + 5 + $urandom % 10;
		wr_reg(ra(1, 4), 8'(n));
		wr_reg(ra(1, 5), 8'h00);
		wr_reg(ra(1, 6), 8'(k));
		wr_reg(ra(1, 7), 8'h00);
		wr_reg(ra(1, 1), 8'hA8);
		wr_reg(ra(1, 0), 8'h18);
		wait_pin(1, 1'b1, t);
		wait_pin(1, 1'b0, t);
		check(16'(t), 16'(n));
		wait_pin(1, 1'b1, t);
		check(16'(t), 16'(k - n));
		wr_reg(ra(1, 0), 8'h00);
		// Single pulse on periodic one: trigger rise, then n clocks high
		wr_reg(ra(2, 4), 8'(n));
		wr_reg(ra(2, 5), 8'h00);
		wr_reg(ra(2, 1), 8'hB9);
		wr_reg(ra(2, 0), 8'h18);
		repeat (4) @(posedge clk);
		ext_clock_pin[2] <= 1'b1;
		wait_pin(2, 1'b1, t);
		check(16'(t), 16'h0003);
		wait_pin(2, 1'b0, t);
		check(16'(t), 16'(n));
		wr_reg(ra(2, 0), 8'h00);
		ext_clock_pin[2] <= 1'b0;
		// Standard P of 1 matches at a count of 256
		wr_reg(ra(0, 6), 8'h01);
		rd_reg(ra(0, 6), rv);
		check(rv, 8'h01);
		wr_reg(ra(0, 4), 8'hFF);
		wr_reg(ra(0, 5), 8'hFF);
		wr_reg(ra(0, 1), 8'h00);
		wr_reg(tmc_pkg::ADDR_STAT, 8'hFF);
		wr_reg(ra(0, 0), 8'h18);
		t = 0;
		while (irq_p[0] !== 1'b1 && t < 400)
		begin
			@(posedge clk);
			#1;
			t++;
		end
		check(t >= 250 && t <= 262, 1'b1);
		wr_reg(ra(0, 0), 8'h00);
		rd_reg(ra(0, 3), rv);
		check(rv, 8'h00);
		report_and_stop();
	end
endmodule

// ---- rtl/tmc_core.sv ----
// Four timer modules (one 16-bit standard, three 10-bit periodic)
// behind an 8-bit register port. Assumes pins already routed to the
// timers by the pin-sharing logic; high and subsidiary clocks arrive
// as one-cycle tick pulses synchronous to clk.
// How it works
// - Counter ticks from sys/4, sys, high/16, high/64, sub or ext pin.
// - External clock pin counts on rising or falling edge as selected.
// - Single pulse mode uses the external clock pin as trigger.
// - Capture pin edge: rising, falling or both, from pin function field.
// - Periodic modules may capture from their external clock pin instead.
// - Counter is compared with both comparators continuously for a match.
// - Separate interrupt request for comparator A and comparator P.
// - A compare match may clear the counter and change the output.
// - Compare output mode drives output low, high or toggles on match.
// - Output pins carry the PWM waveform in PWM mode.
// - Standard module has 16-bit counter, three periodic have 10-bit.
// - Only standard and periodic zero have an inverted output pin.
// - Each module offers PWM, single pulse, capture, compare, timer.
// - High bytes direct, low bytes through one 8-bit buffer.
// - Low byte write of a comparator only loads the buffer.
// - High byte write also copies the buffer into the low byte.
// - High byte read copies the live low byte into the buffer.
// - Low byte read returns the buffer, not the live low byte.
// - Standard comparator P is 8 bits against counter bits 15 to 8.
// - Enable rising resets the counter; clearing it holds the count.
`timescale 1ns/100ps

module tmc_unit #(
	parameter int W       = 10,
	parameter bit IS_STD  = 1'b0,
	parameter bit HAS_INV = 1'b0
) (
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               rst_n,
	// Register access for this module
	input  wire logic [2:0]         reg_sel,
	input  wire logic               wr,
	input  wire logic               rd,
	input  wire logic [7:0]         wdata,
	output logic      [7:0]         rd_val,
	input  wire logic [1:0]         flag_clr,
	// Clock ticks and pins
	input  wire tmc_pkg::tmc_tick_t tick,
	input  wire logic               ext_clock_pin,
	input  wire logic               capture_pin,
	output logic                    timer_output_pin,
	output logic                    inverted_output_pin,
	output logic                    irq_a,
	output logic                    irq_p
);
	localparam logic [15:0] CMASK = 16'((17'h1 << W) - 17'h1);
	localparam logic [15:0] PMASK = IS_STD ? 16'h00FF : CMASK;

	tmc_pkg::tmc_unit_st_t st_r;
	tmc_pkg::tmc_unit_st_t st_nxt;

	tmc_pkg::tmc_mode_t mode;
	logic [2:0]  cks;
	logic [1:0]  io;
	logic        adv;
	logic        ck_rise;
	logic        ck_fall;
	logic        cap_in;
	logic        cap_prev;
	logic        cap_ev;
	logic [15:0] inc;
	logic        m_a;
	logic        m_p;
	logic        enable;
	logic        run;

	assign mode   = tmc_pkg::tmc_mode_t'(st_r.ctrl1[tmc_pkg::C1_MODE_LSB +: 2]);
	assign cks    = st_r.ctrl0[tmc_pkg::C0_CKS_LSB +: 3];
	assign io     = st_r.ctrl1[tmc_pkg::C1_IO_LSB +: 2];
	assign enable = st_r.ctrl0[tmc_pkg::C0_ENABLE];

	// Edge detect only on the second sync stage
	assign ck_rise = st_r.ck_s2 & ~st_r.ck_d;
	assign ck_fall = ~st_r.ck_s2 & st_r.ck_d;

	// Periodic modules may take capture from their clock pin
	assign cap_in = (!IS_STD && st_r.ctrl0[tmc_pkg::C0_CAPSRC]) ?
		st_r.ck_s2 : st_r.cp_s2;
	assign cap_prev = (!IS_STD && st_r.ctrl0[tmc_pkg::C0_CAPSRC]) ?
		st_r.ck_d : st_r.cp_d;

	// Capture edge choice
	always_comb
	begin
		case (io)
			tmc_pkg::IO_A: cap_ev = cap_in & ~cap_prev;
			tmc_pkg::IO_B: cap_ev = ~cap_in & cap_prev;
			tmc_pkg::IO_C: cap_ev = cap_in ^ cap_prev;
			default:       cap_ev = 1'b0;
		endcase
	end

	// Clock source choice; ext edges feed event counting
	always_comb
	begin
		case (cks)
			tmc_pkg::CKS_SYS4: adv = tick.sys4;
			tmc_pkg::CKS_SYS:  adv = tick.sys;
			tmc_pkg::CKS_HI16: adv = tick.hi16;
			tmc_pkg::CKS_HI64: adv = tick.hi64;
			tmc_pkg::CKS_EXTR: adv = ck_rise;
			tmc_pkg::CKS_EXTF: adv = ck_fall;
			default:           adv = tick.sub;
		endcase
	end

	// Single pulse counts only while its pulse is running
	assign run = enable & ~st_r.ctrl0[tmc_pkg::C0_PAUSE] & st_r.en_d &
		(!(mode == tmc_pkg::TMC_MODE_PWM && io == tmc_pkg::IO_D) ||
		st_r.sp_run);

	// Match is taken on the step into the compare value
	assign inc = (st_r.cnt + 16'h0001) & CMASK;
	assign m_a = run & adv & (inc == (st_r.cmpa & CMASK));
	assign m_p = run & adv & (IS_STD ?
		(inc[15:8] == st_r.cmpp[7:0] && inc[7:0] == 8'h00) :
		(inc == (st_r.cmpp & CMASK)));

	// Register read value, combinational; top registers it
	always_comb
	begin
		case (reg_sel)
			tmc_pkg::REG_CTRL0:   rd_val = st_r.ctrl0 & tmc_pkg::C0_RMASK;
			tmc_pkg::REG_CTRL1:   rd_val = st_r.ctrl1;
			tmc_pkg::REG_CNT_LO:  rd_val = st_r.lo_buf;
			tmc_pkg::REG_CNT_HI:  rd_val = st_r.cnt[15:8];
			tmc_pkg::REG_CMPA_LO: rd_val = st_r.lo_buf;
			tmc_pkg::REG_CMPA_HI: rd_val = st_r.cmpa[15:8];
			tmc_pkg::REG_CMPP_LO: rd_val = IS_STD ? st_r.cmpp[7:0] :
				st_r.lo_buf;
			tmc_pkg::REG_CMPP_HI: rd_val = st_r.cmpp[15:8];
			default:              rd_val = 8'h00;
		endcase
	end

	// Next state of the whole module
	always_comb
	begin
		st_nxt = st_r;
		// Two-stage synchronisers and edge history
		st_nxt.ck_s1 = ext_clock_pin;
		st_nxt.ck_s2 = st_r.ck_s1;
		st_nxt.ck_d  = st_r.ck_s2;
		st_nxt.cp_s1 = capture_pin;
		st_nxt.cp_s2 = st_r.cp_s1;
		st_nxt.cp_d  = cap_in;
		st_nxt.en_d  = enable;

		// Counting; off keeps the residual value
		if (enable && !st_r.en_d)
		begin
			st_nxt.cnt    = 16'h0000;
			st_nxt.sp_run = 1'b0;
			st_nxt.act    = 1'b0;
		end
		else if (run && adv)
		begin
			st_nxt.cnt = inc;
			if ((st_r.ctrl1[tmc_pkg::C1_CCLR] ? m_a : m_p) &&
				mode != tmc_pkg::TMC_MODE_CAP)
				st_nxt.cnt = 16'h0000;
		end

		// Output behaviour per mode
		case (mode)
			tmc_pkg::TMC_MODE_CMP:
			begin
				if (m_a)
				begin
					case (io)
						tmc_pkg::IO_B: st_nxt.act = 1'b0;
						tmc_pkg::IO_C: st_nxt.act = 1'b1;
						tmc_pkg::IO_D: st_nxt.act = ~st_r.act;
						default:       st_nxt.act = st_r.act;
					endcase
				end
				if (enable && !st_r.en_d)
					st_nxt.act = st_r.ctrl1[tmc_pkg::C1_OC];
			end
			tmc_pkg::TMC_MODE_PWM:
			begin
				if (io == tmc_pkg::IO_A)
					st_nxt.act = 1'b0;
				else if (io == tmc_pkg::IO_B)
					st_nxt.act = 1'b1;
				else if (io == tmc_pkg::IO_C)
				begin
					// Duty comparator ends the active part
					if (st_r.ctrl1[tmc_pkg::C1_DPX] ? m_p : m_a)
						st_nxt.act = 1'b0;
					else if (st_r.ctrl1[tmc_pkg::C1_DPX] ? m_a : m_p)
						st_nxt.act = 1'b1;
					else if (enable && !st_r.en_d)
						st_nxt.act = 1'b1;
				end
				else
				begin
					// Trigger edge on the clock pin starts a pulse
					if (enable && st_r.en_d && ck_rise && !st_r.sp_run)
					begin
						st_nxt.sp_run = 1'b1;
						st_nxt.act    = 1'b1;
						st_nxt.cnt    = 16'h0000;
					end
					else if (m_a)
					begin
						st_nxt.sp_run = 1'b0;
						st_nxt.act    = 1'b0;
					end
				end
			end
			default:
				st_nxt.act = st_r.act; // Timer mode leaves pin alone
		endcase

		// Register writes
		if (wr)
		begin
			case (reg_sel)
				tmc_pkg::REG_CTRL0:   st_nxt.ctrl0 = wdata & tmc_pkg::C0_RMASK;
				tmc_pkg::REG_CTRL1:   st_nxt.ctrl1 = wdata;
				tmc_pkg::REG_CMPA_LO: st_nxt.lo_buf = wdata;
				tmc_pkg::REG_CMPA_HI:
					st_nxt.cmpa = {wdata, st_r.lo_buf} & CMASK;
				tmc_pkg::REG_CMPP_LO:
				begin
					if (IS_STD)
						st_nxt.cmpp = {8'h00, wdata};
					else
						st_nxt.lo_buf = wdata;
				end
				tmc_pkg::REG_CMPP_HI:
					if (!IS_STD)
						st_nxt.cmpp = {wdata, st_r.lo_buf} & PMASK;
				default:
					st_nxt.ctrl0 = st_nxt.ctrl0; // Counter is read-only
			endcase
		end

		// High byte reads latch the live low byte
		if (rd)
		begin
			case (reg_sel)
				tmc_pkg::REG_CNT_HI:  st_nxt.lo_buf = st_r.cnt[7:0];
				tmc_pkg::REG_CMPA_HI: st_nxt.lo_buf = st_r.cmpa[7:0];
				tmc_pkg::REG_CMPP_HI:
					if (!IS_STD)
						st_nxt.lo_buf = st_r.cmpp[7:0];
				default:
					st_nxt.lo_buf = st_nxt.lo_buf;
			endcase
		end

		// Capture overrides a same-cycle software write to comparator A
		if (mode == tmc_pkg::TMC_MODE_CAP && enable && cap_ev)
			st_nxt.cmpa = st_r.cnt & CMASK;

		// Pending flags; a new event beats a same-cycle clear
		st_nxt.flag_a = (st_r.flag_a & ~flag_clr[0]) | m_a |
			(mode == tmc_pkg::TMC_MODE_CAP && enable && cap_ev);
		st_nxt.flag_p = (st_r.flag_p & ~flag_clr[1]) | m_p;

		// Pin drive, level set by polarity
		st_nxt.pin = (mode == tmc_pkg::TMC_MODE_PWM) ?
			~(st_nxt.act ^ st_r.ctrl1[tmc_pkg::C1_OC]) ^
			st_r.ctrl1[tmc_pkg::C1_POL] :
			st_nxt.act ^ st_r.ctrl1[tmc_pkg::C1_POL];
		st_nxt.pin_inv = HAS_INV ? ~st_nxt.pin : 1'b0;
	end

	// State register
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign timer_output_pin    = st_r.pin;
	assign inverted_output_pin = st_r.pin_inv;
	assign irq_a               = st_r.flag_a;
	assign irq_p               = st_r.flag_p;
endmodule

module tmc_core (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Register port
	input  wire logic [5:0]  addr,
	input  wire logic [7:0]  wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [7:0]  rdata,
	// Internal clock ticks
	input  wire logic        hi_tick,
	input  wire logic        sub_tick,
	// Pins: index 0 standard, 1..3 periodic zero..two
	input  wire logic [3:0]  ext_clock_pin,
	input  wire logic [3:0]  capture_pin,
	output logic      [3:0]  timer_output_pin,
	output logic      [1:0]  inverted_output_pin,
	// Interrupt requests per module
	output logic      [3:0]  irq_a,
	output logic      [3:0]  irq_p
);
	tmc_pkg::tmc_top_st_t st_r;
	tmc_pkg::tmc_top_st_t st_nxt;
	tmc_pkg::tmc_tick_t   tick;
	tmc_pkg::tmc_req_t    req;

	logic [7:0] rd_val [4];
	logic [3:0] inv;
	logic [7:0] stat;
	logic       stat_sel;

	assign req      = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
	assign stat_sel = (req.addr == tmc_pkg::ADDR_STAT);
	assign stat     = {irq_p[3], irq_a[3], irq_p[2], irq_a[2],
		irq_p[1], irq_a[1], irq_p[0], irq_a[0]};

	// Shared prescalers; each divider serves all four modules
	always_comb
	begin
		tick.sys4 = (st_r.pre_sys == tmc_pkg::SYS_DIV_TC);
		tick.sys  = 1'b1;
		tick.hi16 = hi_tick &&
			((st_r.pre_hi & tmc_pkg::HI16_MASK) == tmc_pkg::HI16_MASK);
		tick.hi64 = hi_tick && (st_r.pre_hi == tmc_pkg::HI64_TC);
		tick.sub  = sub_tick;
	end

	// Four modules: the first is the 16-bit standard one
	for (genvar i = 0; i < 4; i++)
	begin : g_tm
		logic [1:0] clr;
		assign clr = (req.wr && stat_sel) ? req.wdata[2*i +: 2] : 2'b00;
		tmc_unit #(
			.W       (i == 0 ? 16 : 10),
			.IS_STD  (i == 0),
			.HAS_INV (i < 2)
		) u_tm (
			.clk                 (clk),
			.rst_n               (rst_n),
			.reg_sel             (req.addr[2:0]),
			.wr                  (req.wr && !req.addr[5] &&
				req.addr[4:3] == 2'(i)),
			.rd                  (req.rd && !req.addr[5] &&
				req.addr[4:3] == 2'(i)),
			.wdata               (req.wdata),
			.rd_val              (rd_val[i]),
			.flag_clr            (clr),
			.tick                (tick),
			.ext_clock_pin       (ext_clock_pin[i]),
			.capture_pin         (capture_pin[i]),
			.timer_output_pin    (timer_output_pin[i]),
			.inverted_output_pin (inv[i]),
			.irq_a               (irq_a[i]),
			.irq_p               (irq_p[i])
		);
	end

	assign inverted_output_pin = inv[1:0];

	// Prescaler advance and read data capture
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.pre_sys = st_r.pre_sys + 2'h1;
		if (hi_tick)
			st_nxt.pre_hi = st_r.pre_hi + 6'h01;
		// Unmapped reads return zero
		if (req.rd)
		begin
			if (stat_sel)
				st_nxt.rdata = stat;
			else if (!req.addr[5])
				st_nxt.rdata = rd_val[req.addr[4:3]];
			else
				st_nxt.rdata = 8'h00;
		end
	end

	// Top state register
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign rdata = st_r.rdata;
endmodule

// ---- shared/tmc_pkg.sv ----
// Constants, field layouts and state records for the timer core.
// Assumes an 8-bit register port with a 6-bit byte address.
package tmc_pkg;

	// Address layout: [5] status page, [4:3] module, [2:0] register
	localparam int          ADDR_W     = 6;
	localparam logic [5:0]  ADDR_STAT  = 6'h20;
	localparam logic [2:0]  REG_CTRL0  = 3'h0;
	localparam logic [2:0]  REG_CTRL1  = 3'h1;
	localparam logic [2:0]  REG_CNT_LO = 3'h2;
	localparam logic [2:0]  REG_CNT_HI = 3'h3;
	localparam logic [2:0]  REG_CMPA_LO = 3'h4;
	localparam logic [2:0]  REG_CMPA_HI = 3'h5;
	localparam logic [2:0]  REG_CMPP_LO = 3'h6;
	localparam logic [2:0]  REG_CMPP_HI = 3'h7;

	// Control register 0 fields
	localparam int          C0_PAUSE   = 7;
	localparam int          C0_CKS_LSB = 4;
	localparam int          C0_ENABLE  = 3;
	localparam int          C0_CAPSRC  = 0;
	localparam logic [7:0]  C0_RMASK   = 8'hF9;
	// Control register 1 fields
	localparam int          C1_MODE_LSB = 6;
	localparam int          C1_IO_LSB  = 4;
	localparam int          C1_OC      = 3;
	localparam int          C1_POL     = 2;
	localparam int          C1_DPX     = 1;
	localparam int          C1_CCLR    = 0;
	localparam logic [7:0]  CTRL_RST   = 8'h00;

	// Clock select codes
	localparam logic [2:0]  CKS_SYS4   = 3'h0;
	localparam logic [2:0]  CKS_SYS    = 3'h1;
	localparam logic [2:0]  CKS_HI16   = 3'h2;
	localparam logic [2:0]  CKS_HI64   = 3'h3;
	localparam logic [2:0]  CKS_EXTR   = 3'h6;
	localparam logic [2:0]  CKS_EXTF   = 3'h7;

	// Prescaler terminal counts
	localparam logic [1:0]  SYS_DIV_TC = 2'h3;
	localparam logic [5:0]  HI16_MASK  = 6'h0F;
	localparam logic [5:0]  HI64_TC    = 6'h3F;

	// Pin function codes
	localparam logic [1:0]  IO_A       = 2'h0;
	localparam logic [1:0]  IO_B       = 2'h1;
	localparam logic [1:0]  IO_C       = 2'h2;
	localparam logic [1:0]  IO_D       = 2'h3;

	typedef enum logic [1:0] {
		TMC_MODE_CMP,
		TMC_MODE_CAP,
		TMC_MODE_PWM,
		TMC_MODE_TC
	} tmc_mode_t;

	// Register port request
	typedef struct packed {
		logic [5:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} tmc_req_t;

	// Prescaled clock ticks, one bit per source
	typedef struct packed {
		logic sys4;
		logic sys;
		logic hi16;
		logic hi64;
		logic sub;
	} tmc_tick_t;

	// Whole state of one timer module
	typedef struct packed {
		logic [7:0]  ctrl0;
		logic [7:0]  ctrl1;
		logic [15:0] cnt;
		logic [15:0] cmpa;
		logic [15:0] cmpp;
		logic [7:0]  lo_buf;
		logic        en_d;
		logic        sp_run;
		logic        act;
		logic        pin;
		logic        pin_inv;
		logic        flag_a;
		logic        flag_p;
		logic        ck_s1;
		logic        ck_s2;
		logic        ck_d;
		logic        cp_s1;
		logic        cp_s2;
		logic        cp_d;
	} tmc_unit_st_t;

	// State of the top level
	typedef struct packed {
		logic [1:0] pre_sys;
		logic [5:0] pre_hi;
		logic [7:0] rdata;
	} tmc_top_st_t;

endpackage
